// ### hw/bsr_core_ctrl.sv
// Purpose: soft reset and abort request bits of the link core control word
// Assumes: status inputs come from logic on clk_in, no synchronisers needed
// Notes:   request bits self-clear when their action has completed
//
// Summary of operation
// - writing one to bit 31 pulses the core reset, then the bit clears
// - writing one to bit 30 pulses the timing generator reset, then clears
// - writing one to bit 29 pulses the register block reset, then clears
// - writing one to bit 26 stops the running RF test, then clears
// - endless tx abort finishes current byte, then the CRC, then stops
// - endless rx abort finishes packet if address seen, else RF off now
// - writing one to bit 25 ends the advertising event, then clears
// - writing one to bit 24 ends the scan window, then clears
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module bsr_core_ctrl (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [31:0] wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output var  logic [31:0] wb_dat_out,
    output var  logic        wb_ack_out,
    // soft resets
    output var  logic        core_rst_out,
    output var  logic        timing_gen_rst_out,
    output var  logic        reg_blk_rst_out,
    // packet controller, rf test
    input  wire logic        rf_test_active_in,
    input  wire logic        rf_test_tx_mode_in,
    input  wire logic        tx_byte_end_in,
    input  wire logic        tx_crc_end_in,
    input  wire logic        rx_aa_detected_in,
    input  wire logic        rx_packet_end_in,
    output var  logic        rf_test_stop_request_out,
    output var  logic        rf_off_out,
    // event controller
    input  wire logic        adv_event_active_in,
    input  wire logic        scan_window_active_in,
    output var  logic        advertising_stop_request_out,
    output var  logic        scan_stop_request_out
);
    import bsr_pkg::*;

    logic [31:0]       ctrl_r;
    logic [31:0]       ctrl_nxt;
    logic [31:0]       wr_set;
    logic [31:0]       done;
    logic [31:0]       rdat_r;
    logic [31:0]       rdat_nxt;
    logic              ack_r;
    logic              ack_nxt;
    logic              take;
    logic              hit;
    logic [1:0]        rcnt_r   [NUM_RST];
    logic [1:0]        rcnt_nxt [NUM_RST];
    logic [NUM_RST-1:0] rst_r;
    logic [NUM_RST-1:0] rst_nxt;
    logic [NUM_RST-1:0] rst_done;
    bsr_abort_t        st_r;
    bsr_abort_t        st_nxt;
    logic              stop_r;
    logic              stop_nxt;
    logic              off_r;
    logic              off_nxt;
    logic              rf_done;
    logic              adv_done;
    logic              scan_done;

    // bus decode and write strobes
    assign take = wb_cyc_in & wb_stb_in & ~ack_r;
    assign hit  = (wb_adr_in[31:2] == CTRL_ADDR[31:2]);

    always_comb begin
        wr_set   = 32'h0;
        ack_nxt  = take;
        rdat_nxt = 32'h0;
        if (take && wb_we_in && hit && wb_sel_in[SEL_REQ_LANE]) begin
            wr_set = wb_dat_in & CTRL_WMASK;
        end
        if (take && !wb_we_in) begin
            rdat_nxt = hit ? (ctrl_r & CTRL_WMASK) : UNMAPPED_DATA;
        end
    end

    // completion vector; set wins over clear
    assign done = {rst_done[0], rst_done[1], rst_done[2], 2'b00,
                   rf_done, adv_done, scan_done, 24'h0};

    always_comb begin
        ctrl_nxt = (ctrl_r & ~done) | wr_set;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_r <= CTRL_RESET;
            ack_r  <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // soft reset pulses: index 0 core, 1 timing gen, 2 register block
    always_comb begin
        for (int i = 0; i < NUM_RST; i++) begin
            rcnt_nxt[i] = rcnt_r[i];
            rst_done[i] = 1'b0;
            if (rcnt_r[i] == RST_CNT_IDLE) begin
                if (ctrl_r[SYS_RST_BIT - i]) begin
                    rcnt_nxt[i] = RST_HOLD_CNT;
                end
            end else begin
                rcnt_nxt[i] = rcnt_r[i] - RST_CNT_LAST;
                if (rcnt_r[i] == RST_CNT_LAST) begin
                    rst_done[i] = 1'b1;
                end
            end
            rst_nxt[i] = (rcnt_nxt[i] != RST_CNT_IDLE);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < NUM_RST; i++) begin
                rcnt_r[i] <= RST_CNT_IDLE;
            end
            rst_r <= '0;
        end else begin
            for (int i = 0; i < NUM_RST; i++) begin
                rcnt_r[i] <= rcnt_nxt[i];
            end
            rst_r <= rst_nxt;
        end
    end

    // rf test abort sequencing
    always_comb begin
        st_nxt   = st_r;
        stop_nxt = 1'b0;
        off_nxt  = 1'b0;
        rf_done  = 1'b0;
        unique case (st_r)
            BSR_ST_IDLE: begin
                if (ctrl_r[RF_STOP_BIT]) begin
                    if (!rf_test_active_in) begin
                        rf_done = 1'b1;
                    end else if (rf_test_tx_mode_in) begin
                        st_nxt   = BSR_ST_TX_BYTE;
                        stop_nxt = 1'b1;
                    end else if (rx_aa_detected_in) begin
                        st_nxt   = BSR_ST_RX_PKT;
                        stop_nxt = 1'b1;
                    end else begin
                        st_nxt  = BSR_ST_RF_OFF;
                        off_nxt = 1'b1;
                    end
                end
            end
            BSR_ST_TX_BYTE: begin
                stop_nxt = 1'b1;
                if (tx_byte_end_in) begin
                    st_nxt = BSR_ST_TX_CRC;
                end
            end
            BSR_ST_TX_CRC: begin
                stop_nxt = 1'b1;
                if (tx_crc_end_in) begin
                    st_nxt   = BSR_ST_IDLE;
                    stop_nxt = 1'b0;
                    rf_done  = 1'b1;
                end
            end
            BSR_ST_RX_PKT: begin
                stop_nxt = 1'b1;
                if (rx_packet_end_in) begin
                    st_nxt   = BSR_ST_IDLE;
                    stop_nxt = 1'b0;
                    rf_done  = 1'b1;
                end
            end
            BSR_ST_RF_OFF: begin
                st_nxt  = BSR_ST_IDLE;
                rf_done = 1'b1;
            end
            default: begin
                st_nxt = BSR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r   <= BSR_ST_IDLE;
            stop_r <= 1'b0;
            off_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            stop_r <= stop_nxt;
            off_r  <= off_nxt;
        end
    end

    // advertising and scan aborts end when the activity has gone
    assign adv_done  = ctrl_r[ADV_STOP_BIT] & ~adv_event_active_in;
    assign scan_done = ctrl_r[SCAN_STOP_BIT] & ~scan_window_active_in;

    assign wb_dat_out                   = rdat_r;
    assign wb_ack_out                   = ack_r;
    assign core_rst_out                 = rst_r[0];
    assign timing_gen_rst_out           = rst_r[1];
    assign reg_blk_rst_out              = rst_r[2];
    assign rf_test_stop_request_out     = stop_r;
    assign rf_off_out                   = off_r;
    assign advertising_stop_request_out = ctrl_r[ADV_STOP_BIT];
    assign scan_stop_request_out        = ctrl_r[SCAN_STOP_BIT];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // bus handshake and reset
    a_ack_one_cycle: assert property (ack_r |=> !ack_r)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (take |=> ack_r)
        else $error("request not answered next cycle");
    a_rd_mask: assert property (ack_r |-> (rdat_r & ~CTRL_WMASK) == 32'h0)
        else $error("unimplemented bits read nonzero");
    a_sel_ignore: assert property (
        take && wb_we_in && !wb_sel_in[SEL_REQ_LANE] && !ctrl_r[ADV_STOP_BIT]
        |=> !ctrl_r[ADV_STOP_BIT])
        else $error("write without request lane set a bit");
    a_reset_quiet: assert property (disable iff (1'b0)
        sys_rst_in |=> ctrl_r == CTRL_RESET && !ack_r && rst_r == '0 && !stop_r && !off_r)
        else $error("state not idle after reset");

    // soft reset pulses
    a_core_rst_len: assert property ($rose(rst_r[0]) |-> rst_r[0][*2] ##1 !rst_r[0])
        else $error("core reset pulse length wrong");
    a_core_rst_clear: assert property (
        $fell(rst_r[0]) && !$past(wr_set[SYS_RST_BIT]) |-> !ctrl_r[SYS_RST_BIT])
        else $error("core reset request not cleared");
    a_zero_wr_noop: assert property (
        !ctrl_r[SYS_RST_BIT] && !wr_set[SYS_RST_BIT] |=> !ctrl_r[SYS_RST_BIT] && !rst_r[0])
        else $error("zero write started a reset");
    a_tg_rst_len: assert property (
        ctrl_r[TG_RST_BIT] && rcnt_r[1] == RST_CNT_IDLE
        |=> rst_r[1] ##1 rst_r[1] ##1 !rst_r[1])
        else $error("timing generator reset pulse wrong");
    a_tg_rst_clear: assert property (
        $fell(rst_r[1]) && !$past(wr_set[TG_RST_BIT]) |-> !ctrl_r[TG_RST_BIT])
        else $error("timing generator reset request not cleared");
    a_reg_rst_len: assert property (
        $rose(rst_r[2]) |-> ##1 rst_r[2] ##1
        (!rst_r[2] && (!ctrl_r[REG_RST_BIT] || $past(wr_set[REG_RST_BIT]))))
        else $error("register block reset pulse wrong");

    // rf test abort
    a_rf_idle_done: assert property (
        st_r == BSR_ST_IDLE && ctrl_r[RF_STOP_BIT] && !rf_test_active_in
        && !wr_set[RF_STOP_BIT] |=> !ctrl_r[RF_STOP_BIT])
        else $error("rf abort bit not cleared when idle");
    a_rf_bit_held: assert property (
        ctrl_r[RF_STOP_BIT] && st_r != BSR_ST_IDLE && !rf_done |=> ctrl_r[RF_STOP_BIT])
        else $error("rf abort bit cleared before action ended");
    a_stop_held: assert property (
        st_r == BSR_ST_TX_BYTE || st_r == BSR_ST_TX_CRC || st_r == BSR_ST_RX_PKT
        |-> stop_r && ctrl_r[RF_STOP_BIT])
        else $error("stop request dropped while abort runs");
    a_tx_crc_order: assert property (
        st_r == BSR_ST_TX_BYTE && tx_byte_end_in |=> st_r == BSR_ST_TX_CRC && stop_r)
        else $error("tx abort skipped crc stage");
    a_rx_pkt_wait: assert property (
        st_r == BSR_ST_RX_PKT && !rx_packet_end_in |=> st_r == BSR_ST_RX_PKT)
        else $error("rx abort stopped before packet end");
    a_rx_rf_off: assert property (
        st_r == BSR_ST_IDLE && ctrl_r[RF_STOP_BIT] && rf_test_active_in
        && !rf_test_tx_mode_in && !rx_aa_detected_in |=> off_r ##1 !off_r)
        else $error("rx abort without address did not switch rf off");
    a_state_onehot: assert property ($onehot(st_r))
        else $error("abort state not one-hot");

    // advertising and scan aborts
    a_adv_clear: assert property (
        ctrl_r[ADV_STOP_BIT] && !adv_event_active_in && !wr_set[ADV_STOP_BIT]
        |=> !ctrl_r[ADV_STOP_BIT])
        else $error("advertising abort bit not cleared");
    a_scan_clear: assert property (
        ctrl_r[SCAN_STOP_BIT] && !scan_window_active_in && !wr_set[SCAN_STOP_BIT]
        |=> !ctrl_r[SCAN_STOP_BIT])
        else $error("scan abort bit not cleared");
    a_scan_indep: assert property (
        ctrl_r[SCAN_STOP_BIT] && scan_window_active_in |=> ctrl_r[SCAN_STOP_BIT])
        else $error("scan abort bit cleared early");

    c_core_rst: cover property ($fell(rst_r[0]));
    c_tx_abort: cover property (st_r == BSR_ST_TX_CRC && tx_crc_end_in);
    c_rx_pkt:   cover property (st_r == BSR_ST_RX_PKT && rx_packet_end_in);
    c_adv_scan: cover property (adv_done && scan_done);
    c_rf_off:   cover property (off_r);
endmodule : bsr_core_ctrl
`default_nettype wire

// ### hw/bsr_pkg.sv
// Purpose: constants and types for the link core control request bits
// Assumes: 10 MHz core clock, classic Wishbone register access
// Notes:   one register word; only bits 31:29 and 26:24 are implemented
`default_nettype none
package bsr_pkg;
    localparam logic [31:0] CTRL_ADDR      = 32'h4000_0000;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK     = 32'he700_0000;
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
    localparam int          SYS_RST_BIT    = 31;
    localparam int          TG_RST_BIT     = 30;
    localparam int          REG_RST_BIT    = 29;
    localparam int          RF_STOP_BIT    = 26;
    localparam int          ADV_STOP_BIT   = 25;
    localparam int          SCAN_STOP_BIT  = 24;
    localparam int          SEL_REQ_LANE   = 3;
    localparam int          NUM_RST        = 3;
    // reset pulse length
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          RST_HOLD_NS    = 200;
    localparam int          RST_HOLD_CYC   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  RST_HOLD_CNT   = 2'(RST_HOLD_CYC);
    localparam logic [1:0]  RST_CNT_LAST   = 2'h1;
    localparam logic [1:0]  RST_CNT_IDLE   = 2'h0;

    typedef enum logic [4:0] {
        BSR_ST_IDLE    = 5'h01,
        BSR_ST_TX_BYTE = 5'h02,
        BSR_ST_TX_CRC  = 5'h04,
        BSR_ST_RX_PKT  = 5'h08,
        BSR_ST_RF_OFF  = 5'h10
    } bsr_abort_t;
endpackage : bsr_pkg
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: self-checking bench for the soft reset and abort request bits
// Assumes: design acks every request; the bus task waits for it
// Notes:   pulse outputs sampled on the falling edge, bus reads and stop levels on the rising edge; inputs driven on the rising edge,
// except the last clear of aa, driven on a falling edge
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import bsr_pkg::*;
    logic        clk_in, sys_rst_in, cyc, stb, we, rf_act, tx_mode, aa, adv, scan;
    logic [31:0] adr, dat, rd, rdat;
    logic [3:0]  sel;
    logic [2:0]  ev;
    logic        ack, core_rst, tg_rst, reg_rst, rf_stop, rf_off, adv_stop, scan_stop;
    logic [4:0]  dut_o;
    int          n_mismatch, checks, cycles, c;
    assign dut_o = {rf_off, rf_stop, reg_rst, tg_rst, core_rst};

    bsr_core_ctrl i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .core_rst_out(core_rst),
        .timing_gen_rst_out(tg_rst), .reg_blk_rst_out(reg_rst),
        .rf_test_active_in(rf_act), .rf_test_tx_mode_in(tx_mode), .tx_byte_end_in(ev[0]),
        .tx_crc_end_in(ev[1]), .rx_aa_detected_in(aa), .rx_packet_end_in(ev[2]),
        .rf_test_stop_request_out(rf_stop), .rf_off_out(rf_off),
        .adv_event_active_in(adv), .scan_window_active_in(scan),
        .advertising_stop_request_out(adv_stop), .scan_stop_request_out(scan_stop));

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do @(posedge clk_in); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic rd_chk(input logic [31:0] exp, input string msg);
        wb(1'b0, CTRL_ADDR, 32'h0, 4'hf);
        chk(rd, exp, msg);
    endtask : rd_chk

    task automatic cnt_hi(input int idx, input int n);
        c = 0;
        repeat (n) begin
            @(negedge clk_in);
            if (dut_o[idx] === 1'b1) c++;
        end
    endtask : cnt_hi

    task automatic pulse(input logic [2:0] m);
        @(posedge clk_in);
        ev <= m;
        @(posedge clk_in);
        ev <= 3'h0;
    endtask : pulse

    initial begin
        {cyc, stb, we, rf_act, tx_mode, aa, adv, scan} = '0;
        adr = '0;
        dat = '0;
        sel = '0;
        ev = '0;
        sys_rst_in = 1'b1;
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd_chk(CTRL_RESET, "reset value");
        wb(1'b0, 32'h4000_0010, 32'h0, 4'hf);
        chk(rd, UNMAPPED_DATA, "unmapped read");
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, CTRL_ADDR, 32'h1 << (31 - i), 4'h8);
            cnt_hi(i, 6);
            chk(32'(c), 32'h2, "soft reset pulse");
            rd_chk(32'h0, "soft reset self clear");
        end
        $display("test soft resets done");
        {adv, scan} <= 2'b11;
        wb(1'b1, CTRL_ADDR, CTRL_WMASK, 4'h8);
        cnt_hi(0, 6);
        chk(32'(c), 32'h2, "core pulse in multi write");
        rd_chk(32'h0300_0000, "only busy stops remain");
        chk({31'h0, adv_stop}, 32'h1, "adv stop level");
        adv <= 1'b0;
        rd_chk(32'h0100_0000, "adv stop cleared");
        chk({31'h0, scan_stop}, 32'h1, "scan stop level");
        scan <= 1'b0;
        rd_chk(32'h0, "scan stop cleared");
        chk({31'h0, scan_stop}, 32'h0, "scan stop output low");
        {adv, scan} <= 2'b11;
        wb(1'b1, CTRL_ADDR, 32'h0, 4'hf);
        wb(1'b1, CTRL_ADDR, CTRL_WMASK, 4'h7);
        wb(1'b1, 32'h4000_0010, CTRL_WMASK, 4'hf);
        rd_chk(32'h0, "zero or ignored writes");
        {adv, scan} <= 2'b00;
        $display("test multi and ignored writes done");
        {rf_act, tx_mode} <= 2'b11;
        wb(1'b1, CTRL_ADDR, 32'h0400_0000, 4'h8);
        cnt_hi(3, 3);
        chk(32'(c), 32'h3, "stop held before byte end");
        pulse(3'h2);
        cnt_hi(3, 2);
        chk(32'(c), 32'h2, "crc end ignored before byte end");
        pulse(3'h1);
        cnt_hi(3, 3);
        chk(32'(c), 32'h3, "stop held before crc end");
        pulse(3'h2);
        cnt_hi(3, 2);
        chk(32'(c), 32'h0, "stop after crc");
        rd_chk(32'h0, "tx abort self clear");
        tx_mode <= 1'b0;
        aa <= 1'b1;
        wb(1'b1, CTRL_ADDR, 32'h0400_0000, 4'h8);
        cnt_hi(3, 3);
        chk(32'(c), 32'h3, "stop held until packet end");
        pulse(3'h4);
        cnt_hi(3, 2);
        chk(32'(c), 32'h0, "stop after packet end");
        aa <= 1'b0;
        wb(1'b1, CTRL_ADDR, 32'h0400_0000, 4'h8);
        cnt_hi(4, 4);
        chk(32'(c), 32'h1, "rf off pulse");
        rd_chk(32'h0, "rx abort self clear");
        $display("test rf abort done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
